// File: src/timing_pulse_regs.vh
/*
 * Register map, field positions, reset values and bus codes for the
 * frame-sync pulse reset and output offset register bank.
 * Assumes it is included by its bare name from files under src/.
 */
//
// Function
// - a fired strobe resets only pulses enabled: bit 2 ten-field-id, bit 3 audio sync
// - strobe written low-high-low in one frame; resets apply in following frame
// - software pulse reset acts independently of reference-derived resets
// - no-audio variant: audio sync reset enable reads low, software writes low
// - horizontal output timing delayed by 16-bit pixel offset; zero means none
// - vertical output timing delayed by 16-bit line offset; zero means none
`ifndef TIMING_PULSE_REGS_VH
`define TIMING_PULSE_REGS_VH

// ==========================================================
// register indexes and byte addresses (index times four)
// ==========================================================
`define IDX_PULSE_RESET_CTRL 8'h1a
`define IDX_H_OUT_OFFSET     8'h1b
`define IDX_V_OUT_OFFSET     8'h1c
`define ADDR_WIDTH           8
`define REG_WIDTH            16

// ==========================================================
// control register fields
// ==========================================================
`define BIT_SYNC_STROBE      0
`define BIT_TEN_FIELD_EN     2
`define BIT_AUDIO_SYNC_EN    3

// ==========================================================
// reset values
// ==========================================================
`define RST_CTRL_BIT         1'b0
`define RST_OFFSET           16'h0000

// ==========================================================
// bus response codes
// ==========================================================
`define RESP_OKAY            2'b00
`define RESP_SLVERR          2'b10

`endif

// File: src/pulse_delay.v
/*
 * Counts a programmed number of ticks after a trigger and then emits a
 * one-cycle pulse. A zero delay passes the trigger on one cycle later.
 * Assumes trigger is a single-cycle pulse on clk_sys; tick may be a pulse or held high.
 */
`include "timing_pulse_regs.vh"

module pulse_delay
(
    input  wire        clk_sys,
    input  wire        sys_rst,
    input  wire        trigger,
    input  wire        tick,
    input  wire [15:0] delayCount,
    output reg         pulseOut
);

    // ==========================================================
    // countdown
    // ==========================================================
    reg        busy_q;
    reg [15:0] count_q;

    // a trigger during a countdown restarts it; software keeps the
    // offset below one period so this never cuts a valid delay short
    always @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            busy_q   <= 1'b0;
            count_q  <= `RST_OFFSET;
            pulseOut <= 1'b0;
        end
        else if (trigger)
        begin
            pulseOut <= (delayCount == `RST_OFFSET);
            busy_q   <= (delayCount != `RST_OFFSET);
            count_q  <= delayCount;
        end
        else if (busy_q && tick)
        begin
            count_q  <= count_q - 16'h0001;
            pulseOut <= (count_q == 16'h0001);
            busy_q   <= (count_q != 16'h0001);
        end
        else
        begin
            pulseOut <= 1'b0;
        end
    end

endmodule // pulse_delay

// File: src/sync_pulse_reset_and_offset_regs.v
/*
 * Host register bank for the output timing generator: manual reset of
 * the ten-field-id and audio frame sync pulses at a frame boundary, and
 * horizontal/vertical offsets of output timing against the reference.
 * Assumes an AXI4-Lite master on clk_sys and single-cycle frame, field
 * and reference start pulses from logic on the same clock.
 */
// The AXI4-Lite interface to the registers was chosen for this implementation.
`include "timing_pulse_regs.vh"

module sync_pulse_reset_and_offset_regs
#(
    parameter HAS_AUDIO = 1
)
(
    input  wire        clk_sys,
    input  wire        sys_rst,
    // AXI4-Lite slave
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // timing side
    input  wire        outFrameStart,
    input  wire        outFieldStart,
    input  wire        refHStart,
    input  wire        refVStart,
    output reg         tenFieldIdPulseReset,
    output reg         audioFrameSyncPulseReset,
    output reg  [15:0] hOffsetActive,
    output reg  [15:0] vOffsetActive,
    output wire        outHStart,
    output wire        outVStart
);

    // ==========================================================
    // helpers
    // ==========================================================
    localparam [1:0] DEC_NONE = 2'd0;
    localparam [1:0] DEC_CTRL = 2'd1;
    localparam [1:0] DEC_HOFF = 2'd2;
    localparam [1:0] DEC_VOFF = 2'd3;

    // byte address is four times the register index
    function [1:0] decodeAddr;
        input [7:0] addr;
        begin
            if ({2'b00, addr} == {`IDX_PULSE_RESET_CTRL, 2'b00})
                decodeAddr = DEC_CTRL;
            else if ({2'b00, addr} == {`IDX_H_OUT_OFFSET, 2'b00})
                decodeAddr = DEC_HOFF;
            else if ({2'b00, addr} == {`IDX_V_OUT_OFFSET, 2'b00})
                decodeAddr = DEC_VOFF;
            else
                decodeAddr = DEC_NONE;
        end
    endfunction

    // merge the two low byte lanes into a 16-bit register
    function [15:0] mergeLanes;
        input [15:0] old;
        input [31:0] data;
        input [3:0]  strb;
        begin
            mergeLanes[7:0]  = strb[0] ? data[7:0]  : old[7:0];
            mergeLanes[15:8] = strb[1] ? data[15:8] : old[15:8];
        end
    endfunction

    // ==========================================================
    // registers
    // ==========================================================
    reg        syncStrobe_q;
    reg        tenFieldIdResetEnable_q;
    reg        audioFrameSyncResetEnable_q;
    reg [15:0] hOffset_q;
    reg [15:0] vOffset_q;
    reg        strobePrev_q;

    reg [7:0]  awAddr_q;
    reg [31:0] wData_q;
    reg [3:0]  wStrb_q;

    wire       doWrite;
    wire [1:0] writeSel;
    wire [15:0] ctrlMerged;
    wire [1:0] readSel;
    wire       audioBitAllowed;

    assign doWrite         = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
    assign writeSel        = decodeAddr(awAddr_q);
    assign readSel         = decodeAddr(s_axi_araddr);
    assign audioBitAllowed = (HAS_AUDIO != 0);
    assign ctrlMerged      = mergeLanes({12'h000, audioFrameSyncResetEnable_q,
                                         tenFieldIdResetEnable_q, 1'b0, syncStrobe_q},
                                        wData_q, wStrb_q);

    // ==========================================================
    // write channels: address and data taken in either order
    // ==========================================================
    always @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            awAddr_q      <= 8'h00;
            wData_q       <= 32'h00000000;
            wStrb_q       <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awAddr_q      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wData_q      <= s_axi_wdata;
                wStrb_q      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (doWrite)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (writeSel == DEC_NONE) ? `RESP_SLVERR : `RESP_OKAY;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // ==========================================================
    // register storage; reserved control bits are not kept
    // ==========================================================
    always @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            syncStrobe_q                <= `RST_CTRL_BIT;
            tenFieldIdResetEnable_q     <= `RST_CTRL_BIT;
            audioFrameSyncResetEnable_q <= `RST_CTRL_BIT;
            hOffset_q                   <= `RST_OFFSET;
            vOffset_q                   <= `RST_OFFSET;
        end
        else if (doWrite)
        begin
            if (writeSel == DEC_CTRL)
            begin
                syncStrobe_q                <= ctrlMerged[`BIT_SYNC_STROBE];
                tenFieldIdResetEnable_q     <= ctrlMerged[`BIT_TEN_FIELD_EN];
                audioFrameSyncResetEnable_q <= ctrlMerged[`BIT_AUDIO_SYNC_EN]
                                               & audioBitAllowed;
            end
            else if (writeSel == DEC_HOFF)
            begin
                hOffset_q <= mergeLanes(hOffset_q, wData_q, wStrb_q);
            end
            else if (writeSel == DEC_VOFF)
            begin
                vOffset_q <= mergeLanes(vOffset_q, wData_q, wStrb_q);
            end
        end
    end

    // ==========================================================
    // read channel
    // ==========================================================
    always @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `RESP_OKAY;
            s_axi_rdata   <= 32'h00000000;
            if (readSel == DEC_CTRL)
            begin
                s_axi_rdata[`BIT_SYNC_STROBE]   <= syncStrobe_q;
                s_axi_rdata[`BIT_TEN_FIELD_EN]  <= tenFieldIdResetEnable_q;
                s_axi_rdata[`BIT_AUDIO_SYNC_EN] <= audioFrameSyncResetEnable_q;
            end
            else if (readSel == DEC_HOFF)
            begin
                s_axi_rdata[15:0] <= hOffset_q;
            end
            else if (readSel == DEC_VOFF)
            begin
                s_axi_rdata[15:0] <= vOffset_q;
            end
            else
            begin
                s_axi_rresp <= `RESP_SLVERR;
            end
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ==========================================================
    // strobe sequence detector
    // ==========================================================
    localparam [2:0] ST_IDLE  = 3'b001;
    localparam [2:0] ST_HIGH  = 3'b010;
    localparam [2:0] ST_ARMED = 3'b100;

    reg  [2:0] state_q;
    reg  [2:0] state_d;
    reg        fire_d;
    wire       strobeRise;
    wire       strobeFall;

    assign strobeRise = syncStrobe_q & ~strobePrev_q;
    assign strobeFall = ~syncStrobe_q & strobePrev_q;

    // a rise left high across a frame boundary is dropped: the whole
    // low-high-low pulse must sit inside one output frame
    always @*
    begin
        state_d = state_q;
        fire_d  = 1'b0;
        case (state_q)
            ST_IDLE:
            begin
                if (strobeRise)
                    state_d = ST_HIGH;
            end
            ST_HIGH:
            begin
                if (strobeFall && outFrameStart)
                begin
                    fire_d  = 1'b1;
                    state_d = ST_IDLE;
                end
                else if (outFrameStart)
                    state_d = ST_IDLE;
                else if (strobeFall)
                    state_d = ST_ARMED;
            end
            ST_ARMED:
            begin
                if (outFrameStart)
                begin
                    fire_d  = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            default:
            begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // the reset fires from this path alone, never from reference inputs
    always @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            state_q                  <= ST_IDLE;
            strobePrev_q             <= `RST_CTRL_BIT;
            tenFieldIdPulseReset     <= 1'b0;
            audioFrameSyncPulseReset <= 1'b0;
        end
        else
        begin
            state_q                  <= state_d;
            strobePrev_q             <= syncStrobe_q;
            tenFieldIdPulseReset     <= fire_d & tenFieldIdResetEnable_q;
            audioFrameSyncPulseReset <= fire_d & audioFrameSyncResetEnable_q;
        end
    end

    // ==========================================================
    // offsets: shadowed once per field
    // ==========================================================
    always @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            hOffsetActive <= `RST_OFFSET;
            vOffsetActive <= `RST_OFFSET;
        end
        else if (outFieldStart)
        begin
            hOffsetActive <= hOffset_q;
            vOffsetActive <= vOffset_q;
        end
    end

    // horizontal delay counts pixels, vertical counts reference lines
    pulse_delay hDelay
    (
        .clk_sys    (clk_sys),
        .sys_rst    (sys_rst),
        .trigger    (refHStart),
        .tick       (1'b1),
        .delayCount (hOffsetActive),
        .pulseOut   (outHStart)
    );

    pulse_delay vDelay
    (
        .clk_sys    (clk_sys),
        .sys_rst    (sys_rst),
        .trigger    (refVStart),
        .tick       (refHStart),
        .delayCount (vOffsetActive),
        .pulseOut   (outVStart)
    );

endmodule // sync_pulse_reset_and_offset_regs

// File: verification/sync_pulse_reset_and_offset_regs_props.sv
/*
 * Assertions on the timing-side ports of the pulse reset and offset bank.
 * Assumes frame, field and reference pulses are single cycles on clk_sys.
 */
module sync_pulse_regs_chk (
    input logic        clk_sys,
    input logic        sys_rst,
    input logic        outFrameStart,
    input logic        outFieldStart,
    input logic        refHStart,
    input logic        refVStart,
    input logic        tenFieldIdPulseReset,
    input logic        audioFrameSyncPulseReset,
    input logic [15:0] hOffsetActive,
    input logic [15:0] vOffsetActive,
    input logic        outHStart,
    input logic        outVStart
);
    // ==========================================================
    // properties
    // ==========================================================
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    AST_TEN_ONE_CYCLE: assert property (tenFieldIdPulseReset |=> !tenFieldIdPulseReset)
        else $error("ten-field-id reset longer than one cycle");
    AST_TEN_AT_FRAME: assert property ($rose(tenFieldIdPulseReset) |-> $past(outFrameStart))
        else $error("ten-field-id reset away from frame start");
    AST_AUD_AT_FRAME: assert property (audioFrameSyncPulseReset |->
        $past(outFrameStart) ##1 !audioFrameSyncPulseReset)
        else $error("audio sync reset misplaced");
    AST_H_ZERO: assert property (refHStart && hOffsetActive == 16'h0000 |=> outHStart)
        else $error("zero horizontal offset not passed through");
    // a new reference line restarts the count, so only isolated lines are judged
    AST_H_THREE: assert property ((refHStart && hOffsetActive == 16'h0003
        ##1 !refHStart[*3]) |=> outHStart)
        else $error("horizontal delay of three wrong");
    AST_V_ZERO: assert property (refVStart && vOffsetActive == 16'h0000 |=> outVStart)
        else $error("zero vertical offset not passed through");
    AST_H_SHADOW: assert property ($changed(hOffsetActive) |-> $past(outFieldStart))
        else $error("horizontal offset changed off the field point");
    AST_V_SHADOW: assert property ($changed(vOffsetActive) |-> $past(outFieldStart))
        else $error("vertical offset changed off the field point");
endmodule // sync_pulse_regs_chk

bind sync_pulse_reset_and_offset_regs sync_pulse_regs_chk u_chk (.*);

// File: verification/tb_sync_pulse_reset_and_offset_regs.sv
/*
 * Self-checking bench for the pulse reset and offset register bank.
 * Assumes the bank answers AXI4-Lite as its hand-over contract states.
 */
module tb_sync_pulse_reset_and_offset_regs;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end

    logic        clk_sys, sys_rst;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    logic        outFrameStart, outFieldStart, refHStart, refVStart;
    wire         tenFieldIdPulseReset, audioFrameSyncPulseReset, outHStart, outVStart;
    wire  [15:0] hOffsetActive, vOffsetActive;
    int          n_errors, n_compared, cyc, nTen, nAud, nV;
    // assumed output standard: an 8-pixel line and a 6-line frame
    localparam int LINE_PIX    = 8;
    localparam int H_ADV       = 5;
    localparam int FRAME_LINES = 6;
    localparam int V_ADV       = 4;

    sync_pulse_reset_and_offset_regs #(.HAS_AUDIO(1)) u_dut (.*);

    // ==========================================================
    // clock, pulse counters and watchdog
    // ==========================================================
    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
    begin
        cyc++;
        if (tenFieldIdPulseReset === 1'b1) nTen++;
        if (audioFrameSyncPulseReset === 1'b1) nAud++;
        if (outVStart === 1'b1) nV++;
        if (cyc == 3000)
        begin
            n_errors++;
            $display("ERROR watchdog expected done seen timeout");
            give_verdict();
        end
    end

    // ==========================================================
    // bus and timing tasks
    // ==========================================================
    // bready and rready stay high, so each answer is taken at the edge it is seen
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {16'h0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        `CHK("bresp", er, s_axi_bresp)
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] ed, input logic [1:0] er);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        `CHK("rresp", er, s_axi_rresp)
        if (er == 2'b00) `CHK("rdata", {16'h0000, ed}, s_axi_rdata)
    endtask

    // s: 0 frame, 1 field, 2 reference line, 3 reference frame
    task automatic pulse(input int s, input int gap);
        outFrameStart <= (s == 0);
        outFieldStart <= (s == 1);
        refHStart     <= (s == 2);
        refVStart     <= (s == 3);
        @(posedge clk_sys);
        {outFrameStart, outFieldStart, refHStart, refVStart} <= 4'h0;
        repeat (gap) @(posedge clk_sys);
    endtask

    // the pulse is launched n edges after the trigger edge and seen one edge later
    task automatic hmeas(input int n);
        int k;
        k = 0;
        pulse(2, 0);
        do
        begin
            @(posedge clk_sys);
            k++;
        end while (outHStart !== 1'b1 && k < 40);
        `CHK("hDelay", n + 1, k)
    endtask

    task automatic give_verdict();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ==========================================================
    // tests
    // ==========================================================
    initial
    begin
        sys_rst = 1'b1;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
        {s_axi_bready, s_axi_rready} = 2'h3;
        s_axi_wstrb = 4'h3;
        {outFrameStart, outFieldStart, refHStart, refVStart} = 4'h0;
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rd(8'h68, 16'h0000, 2'b00);
        rd(8'h6c, 16'h0000, 2'b00);
        rd(8'h70, 16'h0000, 2'b00);
        rd(8'h00, 16'h0000, 2'b10);
        wr(8'h74, 16'h1234, 2'b10);
        pulse(3, 2);
        `CHK("vZero", 1, nV)
        hmeas(0);
        $display("test reset values done");
        wr(8'h68, 16'h000c, 2'b00);
        rd(8'h68, 16'h000c, 2'b00);
        pulse(0, 3);
        `CHK("noStrobe", 0, nTen)
        wr(8'h68, 16'h000d, 2'b00);
        pulse(3, 1);
        wr(8'h68, 16'h000c, 2'b00);
        pulse(0, 3);
        `CHK("tenBoth", 1, nTen)
        `CHK("audBoth", 1, nAud)
        wr(8'h68, 16'h0004, 2'b00);
        wr(8'h68, 16'h0005, 2'b00);
        wr(8'h68, 16'h0004, 2'b00);
        pulse(0, 3);
        `CHK("tenOnly", 2, nTen)
        `CHK("audOff", 1, nAud)
        wr(8'h68, 16'h0005, 2'b00);
        pulse(0, 3);
        wr(8'h68, 16'h0004, 2'b00);
        pulse(0, 3);
        `CHK("dropped", 2, nTen)
        $display("test strobe done");
        wr(8'h6c, 16'(LINE_PIX - H_ADV), 2'b00);
        wr(8'h70, 16'(FRAME_LINES - V_ADV), 2'b00);
        rd(8'h6c, 16'h0003, 2'b00);
        `CHK("hHeld", 16'h0000, hOffsetActive)
        pulse(1, 2);
        `CHK("hLoaded", 16'h0003, hOffsetActive)
        `CHK("vLoaded", 16'h0002, vOffsetActive)
        hmeas(3);
        pulse(3, 3);
        pulse(2, 3);
        // two zero-offset frame pulses have already been counted
        `CHK("vEarly", 2, nV)
        pulse(2, 3);
        `CHK("vTwo", 3, nV)
        $display("test offsets done");
        give_verdict();
    end
endmodule // tb_sync_pulse_reset_and_offset_regs
